// ==== design/ttxhqc_top.sv ====
// Teletext Hamming decoder, quality counters and magazine storage gating
//
// How it works
// - 24/18 position from complemented P5..P1 checks
// - Flag error on bad position or double error
// - Invert indicated bit, clear error flag
// - P1..P5 all one: accept, no error
// - 8/4 checks A..D, correct or flag
// - Count bad line pulses in four bits
// - Counters clear on vsync, saturate at F
// - Count 8/4 errors in two address bytes
// - One count per erroneous byte
// - Quality register read-only, two nibbles
// - Lock and open bits gate magazine storage
// - Header sets flag, software clears it
// - Header starts or restarts an unlocked page
// - Mode bit selects 8/4 or 24/18
// - Seven-bit framing match sets flag
// - Accept bit admits seven-bit framing codes
// - Requested service packet sets its flag
// - Enable bits gate packets 29 to 31
// - 24/18 error clears all data bits
// - 8/4 data in 3:0, error bit 4
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module ttxhqc_top (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Sync extractor and framing detection
  input  wire logic                       vsyncPulse,
  input  wire logic                       vbiActive,
  input  wire logic                       badLinePulse,
  input  wire ttxhqc_pkg::ttxhqc_frame_type frameEvent,
  input  wire ttxhqc_pkg::ttxhqc_byte_type  slicedByte,
  // Storage gating
  output logic                            storeEnable,
  output logic                            pageStart,
  output logic      [2:0]                 storeMagazine,
  output logic      [4:0]                 storeRow
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode functions

  function automatic logic [3:0] ham84_synd(input logic [7:0] b);
    ham84_synd = {b[7] ^ b[5] ^ b[1] ^ b[0],
                  b[7] ^ b[3] ^ b[2] ^ b[1],
                  b[5] ^ b[4] ^ b[3] ^ b[1],
                  ^b};
  endfunction

  // Returns {err, d4..d1}
  function automatic logic [4:0] ham84(input logic [7:0] b);
    logic [3:0] s;
    logic [3:0] d;
    s = ham84_synd(b);
    d = {b[7], b[5], b[3], b[1]};
    ham84 = {1'b0, d};
    case (s)
      4'b0000: ham84 = {1'b0, d ^ 4'b0001};
      4'b0010: ham84 = {1'b0, d ^ 4'b1000};
      4'b0100: ham84 = {1'b0, d ^ 4'b0100};
      4'b1000: ham84 = {1'b0, d ^ 4'b0010};
      default: begin
        // Single errors in check bits are accepted unchanged
        if (s[0] && s != ttxhqc_pkg::SYND_CLEAN) begin
          ham84 = 5'h10;
        end
      end
    endcase
  endfunction

  function automatic logic [23:0] ham2418(input logic [23:0] b);
    logic [4:0]  chk;
    logic        p6;
    logic [4:0]  pos;
    logic        err;
    logic [23:0] c;
    chk[0] = b[0] ^ b[2] ^ b[4] ^ b[6] ^ b[8] ^ b[10] ^ b[12] ^ b[14] ^ b[16] ^ b[18]
             ^ b[20] ^ b[22];
    chk[1] = b[1] ^ b[2] ^ b[5] ^ b[6] ^ b[9] ^ b[10] ^ b[13] ^ b[14] ^ b[17] ^ b[18]
             ^ b[21] ^ b[22];
    chk[2] = b[3] ^ b[4] ^ b[5] ^ b[6] ^ b[11] ^ b[13] ^ b[14] ^ b[19] ^ b[20] ^ b[21]
             ^ b[22];
    chk[3] = ^b[14:7];
    chk[4] = ^b[22:15];
    p6     = ^b;
    pos    = ~chk;
    c      = b;
    err    = 1'b0;
    if (chk == 5'h1f) begin
      err = 1'b0;
    end else if (!p6) begin
      if (pos == 5'h00 || pos > ttxhqc_pkg::POS_LIMIT) begin
        err = 1'b1;
      end else begin
        c = b ^ (24'h000001 << (pos - 5'h01));
      end
    end else begin
      err = 1'b1;
    end
    ham2418 = {err, c[22:16], 3'b000, c[14:10], 2'b00, c[9:8], c[6:4], c[2]};
    if (err) begin
      ham2418 = 24'h800000;
    end
  endfunction

  function automatic logic [3:0] sat_inc(input logic [3:0] v);
    sat_inc = (v == ttxhqc_pkg::COUNT_MAX) ? v : v + 4'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [7:0]  pageOpen_ff;
  logic [7:0]  magLock_ff;
  logic [7:0]  newHeader_ff;
  logic [7:0]  pktRequest_ff;
  logic [3:0]  hamCount_ff;
  logic [3:0]  badCount_ff;
  logic [23:0] decodeInput_ff;
  logic [31:0] prdata_ff;
  logic [23:0] decodeWord;
  logic [7:0]  qualityValue;
  logic [7:0]  readByte;
  logic        mapped;
  logic        wrEn;
  logic        rdSetup;
  logic [7:0]  regIdx;

  assign regIdx  = paddr[9:2];
  assign mapped  = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00)
                   && (regIdx >= ttxhqc_pkg::IDX_PAGE_OPEN);
  assign wrEn    = psel && penable && pwrite && mapped;
  assign rdSetup = psel && !penable;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_ff;

  // Decode result is purely combinational on the input registers
  always_comb begin
    if (pktRequest_ff[ttxhqc_pkg::POS_MODE_SELECT]) begin
      decodeWord = ham2418(decodeInput_ff);
    end else begin
      decodeWord = {19'h00000, ham84(decodeInput_ff[7:0])};
    end
  end

  assign qualityValue = {hamCount_ff, badCount_ff};

  always_comb begin
    case (regIdx)
      ttxhqc_pkg::IDX_PAGE_OPEN:   readByte = pageOpen_ff;
      ttxhqc_pkg::IDX_MAG_LOCK:    readByte = magLock_ff;
      ttxhqc_pkg::IDX_NEW_HEADER:  readByte = newHeader_ff;
      ttxhqc_pkg::IDX_PKT_REQUEST: readByte = {pktRequest_ff[7], 1'b0, pktRequest_ff[5:0]};
      ttxhqc_pkg::IDX_QUALITY:     readByte = qualityValue;
      ttxhqc_pkg::IDX_DEC_HIGH:    readByte = decodeWord[23:16];
      ttxhqc_pkg::IDX_DEC_MID:     readByte = decodeWord[15:8];
      ttxhqc_pkg::IDX_DEC_LOW:     readByte = decodeWord[7:0];
      default:                     readByte = 8'h00;
    endcase
  end

  // Read data captured at the end of the setup cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= 32'h00000000;
    end else if (rdSetup) begin
      prdata_ff <= mapped ? {24'h000000, readByte} : 32'h00000000;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      magLock_ff <= ttxhqc_pkg::RST_MAG_LOCK;
    end else if (wrEn && regIdx == ttxhqc_pkg::IDX_MAG_LOCK) begin
      magLock_ff <= pwdata[7:0];
    end
  end

  // Software writes the code bytes in any order; the last write completes the word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      decodeInput_ff <= {3{ttxhqc_pkg::RST_DEC_INPUT}};
    end else if (wrEn) begin
      case (regIdx)
        ttxhqc_pkg::IDX_DEC_HIGH: decodeInput_ff[23:16] <= pwdata[7:0];
        ttxhqc_pkg::IDX_DEC_MID:  decodeInput_ff[15:8]  <= pwdata[7:0];
        ttxhqc_pkg::IDX_DEC_LOW:  decodeInput_ff[7:0]   <= pwdata[7:0];
        default:                  decodeInput_ff <= decodeInput_ff;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet address capture after framing

  ttxhqc_pkg::ttxhqc_state_type state_ff;
  logic [4:0] firstByte_ff;
  logic       frameAccept;
  logic [4:0] curDec;
  logic       curErr;
  logic [2:0] pktMag;
  logic [4:0] pktRow;
  logic       pktDone;
  logic       isHeader;
  logic       isService;
  logic       svcEnabled;
  logic       unlocked;
  logic [7:0] magBit;

  assign frameAccept = frameEvent.valid && (frameEvent.match8
                       || (frameEvent.match7 && pktRequest_ff[ttxhqc_pkg::POS_FRAME7_ACC]));
  assign curDec  = ham84(slicedByte.data);
  assign curErr  = ham84_synd(slicedByte.data) != ttxhqc_pkg::SYND_CLEAN;
  assign pktDone = (state_ff == ttxhqc_pkg::ST_BYTE2) && slicedByte.valid;
  assign pktMag  = firstByte_ff[2:0];
  assign pktRow  = {curDec[3:0], firstByte_ff[3]};
  assign magBit  = 8'h01 << pktMag;
  assign unlocked   = (magLock_ff & magBit) == 8'h00;
  assign isHeader   = pktDone && !firstByte_ff[4] && !curDec[4] && pktRow == ttxhqc_pkg::ROW_HEADER;
  assign isService  = pktRow >= ttxhqc_pkg::ROW_SVC_FIRST;
  assign svcEnabled = isService && pktRequest_ff[3'(pktRow - ttxhqc_pkg::ROW_SVC_FIRST)];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= ttxhqc_pkg::ST_IDLE;
      firstByte_ff <= 5'h00;
    end else begin
      case (state_ff)
        ttxhqc_pkg::ST_IDLE: begin
          if (frameAccept) begin
            state_ff <= ttxhqc_pkg::ST_BYTE1;
          end
        end
        ttxhqc_pkg::ST_BYTE1: begin
          if (slicedByte.valid) begin
            firstByte_ff <= curDec;
            state_ff     <= ttxhqc_pkg::ST_BYTE2;
          end
        end
        ttxhqc_pkg::ST_BYTE2: begin
          if (slicedByte.valid) begin
            state_ff <= ttxhqc_pkg::ST_IDLE;
          end
        end
        default: state_ff <= ttxhqc_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quality counters

  logic countByte;
  assign countByte = slicedByte.valid && curErr && vbiActive
                     && (state_ff == ttxhqc_pkg::ST_BYTE1 || state_ff == ttxhqc_pkg::ST_BYTE2);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      badCount_ff <= ttxhqc_pkg::RST_COUNT;
    end else if (vsyncPulse) begin
      badCount_ff <= ttxhqc_pkg::RST_COUNT;
    end else if (badLinePulse) begin
      badCount_ff <= sat_inc(badCount_ff);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hamCount_ff <= ttxhqc_pkg::RST_COUNT;
    end else if (vsyncPulse) begin
      hamCount_ff <= ttxhqc_pkg::RST_COUNT;
    end else if (countByte) begin
      hamCount_ff <= sat_inc(hamCount_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Magazine control and flags; a hardware set wins over a software clear

  logic [7:0] headerSet;
  logic [7:0] openSet;
  logic       svcHit;
  assign headerSet = isHeader ? magBit : 8'h00;
  assign openSet   = (isHeader && unlocked) ? magBit : 8'h00;
  assign svcHit    = pktDone && !curDec[4] && isService && svcEnabled;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      newHeader_ff <= ttxhqc_pkg::RST_NEW_HEADER;
    end else if (wrEn && regIdx == ttxhqc_pkg::IDX_NEW_HEADER) begin
      newHeader_ff <= (newHeader_ff & pwdata[7:0]) | headerSet;
    end else begin
      newHeader_ff <= newHeader_ff | headerSet;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pageOpen_ff <= ttxhqc_pkg::RST_PAGE_OPEN;
    end else if (wrEn && regIdx == ttxhqc_pkg::IDX_PAGE_OPEN) begin
      pageOpen_ff <= pwdata[7:0] | openSet;
    end else begin
      pageOpen_ff <= pageOpen_ff | openSet;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pktRequest_ff <= ttxhqc_pkg::RST_PKT_REQUEST;
    end else begin
      if (wrEn && regIdx == ttxhqc_pkg::IDX_PKT_REQUEST) begin
        pktRequest_ff[7]   <= pwdata[7];
        pktRequest_ff[6]   <= 1'b0;
        pktRequest_ff[4]   <= pwdata[4];
        pktRequest_ff[2:0] <= pwdata[2:0];
        pktRequest_ff[5]   <= (pktRequest_ff[5] & pwdata[5])
                              | (frameEvent.valid & frameEvent.match7);
        pktRequest_ff[3]   <= (pktRequest_ff[3] & pwdata[3]) | svcHit;
      end else begin
        pktRequest_ff[5]   <= pktRequest_ff[5] | (frameEvent.valid & frameEvent.match7);
        pktRequest_ff[3]   <= pktRequest_ff[3] | svcHit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage decision per packet

  logic storeNow;
  always_comb begin
    storeNow = 1'b0;
    if (pktDone && !firstByte_ff[4] && !curDec[4] && unlocked) begin
      if (isHeader) begin
        storeNow = 1'b1;
      end else if (isService) begin
        storeNow = svcEnabled;
      end else begin
        storeNow = (pageOpen_ff & magBit) != 8'h00;
      end
    end
  end

  logic       storeEnable_ff;
  logic       pageStart_ff;
  logic [2:0] storeMagazine_ff;
  logic [4:0] storeRow_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      storeEnable_ff   <= 1'b0;
      pageStart_ff     <= 1'b0;
      storeMagazine_ff <= 3'h0;
      storeRow_ff      <= 5'h00;
    end else begin
      storeEnable_ff <= storeNow;
      pageStart_ff   <= storeNow && isHeader;
      if (pktDone) begin
        storeMagazine_ff <= pktMag;
        storeRow_ff      <= pktRow;
      end
    end
  end

  assign storeEnable   = storeEnable_ff;
  assign pageStart     = pageStart_ff;
  assign storeMagazine = storeMagazine_ff;
  assign storeRow      = storeRow_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_CLEAN_ACCEPT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pktRequest_ff[7] && decodeInput_ff[22:0] == 23'h00808b) |-> !decodeWord[23])
    else $error("clean 24/18 word flagged");
  AST_ERR_CLEARS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pktRequest_ff[7] && decodeWord[23]) |-> decodeWord[22:0] == 23'h000000)
    else $error("data not cleared on error");
  AST_DOUBLE_ERR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pktRequest_ff[7] && decodeInput_ff == 24'h00809f) |-> decodeWord[23])
    else $error("double error not flagged");
  AST_SINGLE_FIX: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pktRequest_ff[7] && decodeInput_ff == 24'h00808f) |-> decodeWord == 24'h000000)
    else $error("single error not corrected");
  AST_HAM84_B1: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!pktRequest_ff[7] && ham84_synd(decodeInput_ff[7:0]) == 4'b0000)
      |-> decodeWord[4:0] == {1'b0, decodeInput_ff[7], decodeInput_ff[5], decodeInput_ff[3],
                              !decodeInput_ff[1]})
    else $error("8/4 b1 correction wrong");
  AST_VSYNC_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    vsyncPulse |=> qualityValue == 8'h00)
    else $error("counters not cleared on vsync");
  AST_SATURATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (badCount_ff == 4'hf && !vsyncPulse) |=> badCount_ff == 4'hf)
    else $error("bad line counter wrapped");
  AST_BAD_INC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (badLinePulse && !vsyncPulse && badCount_ff != 4'hf)
      |=> badCount_ff == $past(badCount_ff) + 4'h1)
    else $error("bad line not counted");
  AST_HAM_ONE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!vsyncPulse && !countByte) |=> hamCount_ff == $past(hamCount_ff))
    else $error("hamming count moved without cause");
  AST_HDR_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
    isHeader |=> (newHeader_ff & $past(magBit)) != 8'h00)
    else $error("new header flag not set");
  AST_FR7_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (frameEvent.valid && frameEvent.match7) |=> pktRequest_ff[5])
    else $error("seven bit framing flag not set");
  AST_LOCK_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pktDone && !unlocked) |=> !storeEnable)
    else $error("locked magazine stored");

  CV_CORRECT24: cover property (@(posedge clk_sys) pktRequest_ff[7] && !decodeWord[23]
                                && decodeInput_ff[22:0] != 23'h000000);
  CV_SATURATE:  cover property (@(posedge clk_sys) hamCount_ff == 4'hf);
  CV_PAGESTART: cover property (@(posedge clk_sys) pageStart);
  CV_SERVICE:   cover property (@(posedge clk_sys) svcHit);

endmodule

// ==== design/ttxhqc_pkg.sv ====
// Package: register map, field positions, carriers and states of the teletext quality block
package ttxhqc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PAGE_OPEN   = 8'hf8;
  localparam logic [7:0] IDX_MAG_LOCK    = 8'hf9;
  localparam logic [7:0] IDX_NEW_HEADER  = 8'hfa;
  localparam logic [7:0] IDX_PKT_REQUEST = 8'hfb;
  localparam logic [7:0] IDX_QUALITY     = 8'hfc;
  localparam logic [7:0] IDX_DEC_HIGH    = 8'hfd;
  localparam logic [7:0] IDX_DEC_MID     = 8'hfe;
  localparam logic [7:0] IDX_DEC_LOW     = 8'hff;

  // Reset values
  localparam logic [7:0] RST_PAGE_OPEN   = 8'h00;
  localparam logic [7:0] RST_MAG_LOCK    = 8'h00;
  localparam logic [7:0] RST_NEW_HEADER  = 8'h00;
  localparam logic [7:0] RST_PKT_REQUEST = 8'h00;
  localparam logic [3:0] RST_COUNT       = 4'h0;
  localparam logic [7:0] RST_DEC_INPUT   = 8'h00;

  // Packet request control field positions
  localparam int POS_MODE_SELECT  = 7;
  localparam int POS_FRAME7_FLAG  = 5;
  localparam int POS_FRAME7_ACC   = 4;
  localparam int POS_SVC_FLAG     = 3;
  localparam int POS_SVC_EN_29    = 0;

  // Quality register nibble positions
  localparam int POS_HAM_COUNT    = 4;
  localparam int POS_BAD_COUNT    = 0;

  // Counter limits and decode figures
  localparam logic [3:0] COUNT_MAX     = 4'hf;
  localparam logic [4:0] POS_LIMIT     = 5'h17;
  localparam logic [3:0] SYND_CLEAN    = 4'hf;
  localparam logic [4:0] ROW_HEADER    = 5'h00;
  localparam logic [4:0] ROW_SVC_FIRST = 5'h1d;

  // Byte from the slicer
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ttxhqc_byte_type;

  // Framing code detection result
  typedef struct packed {
    logic valid;
    logic match8;
    logic match7;
  } ttxhqc_frame_type;

  // Packet address bytes capture
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BYTE1 = 2'b01,
    ST_BYTE2 = 2'b10
  } ttxhqc_state_type;

endpackage

// ==== testbench/ttxhqc_feed.sv ====
// Behavioural sync extractor and framing detector in front of the block
`timescale 1ns/1ps
module ttxhqc_feed (
  // Clock
  input  wire logic                    clk_sys,
  // Toward the block
  output logic                         vsyncPulse,
  output logic                         vbiActive,
  output logic                         badLinePulse,
  output ttxhqc_pkg::ttxhqc_frame_type frameEvent,
  output ttxhqc_pkg::ttxhqc_byte_type  slicedByte,
  // Storage gating back from the block
  input  wire logic                    storeEnable,
  input  wire logic                    pageStart
);
  ////////////////////////////////////////////////////////////////
  initial begin
    vsyncPulse = 1'b0;
    vbiActive = 1'b0;
    badLinePulse = 1'b0;
    frameEvent = '0;
    slicedByte = '0;
  end
  // Hamming 8/4 coder: data on b7,b5,b3,b1, every check odd
  function automatic logic [7:0] h84(input logic [3:0] n);
    logic [7:0] b;
    b = {n[3], 1'b0, n[2], 1'b0, n[1], 1'b0, n[0], 1'b0};
    b[0] = ~(b[7] ^ b[5] ^ b[1]);
    b[2] = ~(b[7] ^ b[3] ^ b[1]);
    b[4] = ~(b[5] ^ b[3] ^ b[1]);
    b[6] = ~(^b);
    return b;
  endfunction
  task automatic vbi(input logic on);
    @(posedge clk_sys);
    vbiActive <= on;
  endtask
  // One-cycle vertical sync or bad line pulse
  task automatic pulse(input logic vs);
    @(posedge clk_sys);
    vsyncPulse <= vs;
    badLinePulse <= ~vs;
    @(posedge clk_sys);
    vsyncPulse <= 1'b0;
    badLinePulse <= 1'b0;
  endtask
  // Framing byte then two address bytes; bad=1 single error, bad=2 double
  task automatic packet(input logic [2:0] mag, input logic [4:0] row, input logic m7,
                        input logic [1:0] bad, output logic st, output logic ps);
    logic [7:0] b1;
    logic [7:0] b2;
    b1 = h84({row[0], mag}) ^ (bad[1] ? 8'ha0 : {6'h0, bad[0], 1'b0});
    b2 = h84(row[4:1]);
    @(posedge clk_sys);
    frameEvent <= {1'b1, ~m7, m7};
    @(posedge clk_sys);
    frameEvent <= '0;
    slicedByte <= {1'b1, b1};
    @(posedge clk_sys);
    slicedByte <= {1'b1, b2};
    @(posedge clk_sys);
    // Idle data line flips so a stale byte is never mistaken for a fresh one
    slicedByte <= {1'b0, ~b2};
    #1;
    st = storeEnable;
    ps = pageStart;
  endtask
endmodule

// ==== testbench/tb_teletext_hamming_quality_control.sv ====
// Self-checking bench of the teletext decoder, counters and storage gating
`timescale 1ns/1ps
module tb_teletext_hamming_quality_control;
  ////////////////////////////////////////////////////////////////
  logic                         clk_sys;
  logic                         rst_n;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic [11:0]                  paddr;
  logic [31:0]                  pwdata;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  logic                         vsyncPulse;
  logic                         vbiActive;
  logic                         badLinePulse;
  logic                         storeEnable;
  logic                         pageStart;
  logic [2:0]                   storeMagazine;
  logic [4:0]                   storeRow;
  logic [31:0]                  rd;
  logic                         er;
  logic                         st;
  logic                         ps;
  logic [1:0]                   addrHi;
  int                           num_errors;
  int                           checks;
  ttxhqc_pkg::ttxhqc_frame_type frameEvent;
  ttxhqc_pkg::ttxhqc_byte_type  slicedByte;
  // Zero-data 24/18 codeword, all checks pass
  localparam logic [23:0] CLEAN24 = 24'h00808b;
  ////////////////////////////////////////////////////////////////
  ttxhqc_top DUT (
    .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .vsyncPulse, .vbiActive, .badLinePulse, .frameEvent, .slicedByte,
    .storeEnable, .pageStart, .storeMagazine, .storeRow
  );
  ttxhqc_feed feed (
    .clk_sys, .vsyncPulse, .vbiActive, .badLinePulse, .frameEvent, .slicedByte,
    .storeEnable, .pageStart
  );
  always #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Bounded wait on pready so a stuck slave cannot hang the run
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {addrHi, idx, 2'h0};
    pwdata <= {4{wd}};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      num_errors++;
      stop_test();
    end
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  task automatic d24(input logic [23:0] f, input logic [7:0] hi);
    logic [23:0] w;
    w = CLEAN24 ^ f;
    apb(1'b1, 8'hfd, w[23:16]);
    apb(1'b1, 8'hfe, w[15:8]);
    apb(1'b1, 8'hff, w[7:0]);
    rdc(8'hfd, hi);
    rdc(8'hfe, 8'h00);
    rdc(8'hff, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    addrHi = 2'h0;
    num_errors = 0;
    checks = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rdc(8'hf8 + 8'(i), 8'h00);
    end
    apb(1'b0, 8'h10, 8'h00);
    chk({31'h0, er}, 32'h1);
    // Upper address bits outside the register window must be refused
    addrHi = 2'h3;
    apb(1'b1, 8'hf8, 8'h5a);
    chk({31'h0, er}, 32'h1);
    addrHi = 2'h0;
    rdc(8'hf8, 8'h00);
    apb(1'b1, 8'hfc, 8'hff);
    rdc(8'hfc, 8'h00);
    apb(1'b1, 8'hfb, 8'h97);
    rdc(8'hfb, 8'h97);
    $display("test registers done");
    apb(1'b1, 8'hfb, 8'h00);
    // Clean byte and every single-bit error all give the same nibble
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, 8'hff, feed.h84(4'ha) ^ (8'h01 << i));
      rdc(8'hff, 8'h0a);
    end
    apb(1'b1, 8'hff, feed.h84(4'ha) ^ 8'ha0);
    rdc(8'hff, 8'h10);
    $display("test decode 8/4 done");
    apb(1'b1, 8'hfb, 8'h80);
    // Bit 12 is skipped: its third check membership is left open
    for (int i = 0; i < 25; i++) begin
      if (i != 12) begin
        d24(24'h000001 << i, 8'h00);
      end
    end
    d24(24'h000014, 8'h80);
    d24(24'h404001, 8'h80);
    $display("test decode 24/18 done");
    apb(1'b1, 8'hfb, 8'h00);
    feed.vbi(1'b1);
    repeat (3) feed.pulse(1'b0);
    feed.packet(3'h7, 5'h05, 1'b0, 2'h1, st, ps);
    feed.packet(3'h7, 5'h05, 1'b0, 2'h2, st, ps);
    chk({31'h0, st}, 32'h0);
    feed.vbi(1'b0);
    feed.packet(3'h7, 5'h05, 1'b0, 2'h1, st, ps);
    rdc(8'hfc, 8'h23);
    feed.vbi(1'b1);
    for (int i = 0; i < 17; i++) begin
      feed.pulse(1'b0);
      feed.packet(3'h7, 5'h05, 1'b0, 2'h2, st, ps);
    end
    rdc(8'hfc, 8'hff);
    feed.pulse(1'b1);
    rdc(8'hfc, 8'h00);
    $display("test counters done");
    feed.packet(3'h3, 5'h05, 1'b0, 2'h0, st, ps);
    chk({31'h0, st}, 32'h0);
    feed.packet(3'h3, 5'h00, 1'b0, 2'h0, st, ps);
    chk({30'h0, st, ps}, 32'h3);
    chk({24'h0, storeMagazine, storeRow}, 32'h60);
    rdc(8'hfa, 8'h08);
    rdc(8'hf8, 8'h08);
    feed.packet(3'h3, 5'h05, 1'b0, 2'h0, st, ps);
    chk({30'h0, st, ps}, 32'h2);
    feed.packet(3'h3, 5'h00, 1'b0, 2'h0, st, ps);
    chk({30'h0, st, ps}, 32'h3);
    apb(1'b1, 8'hf9, 8'h04);
    feed.packet(3'h2, 5'h00, 1'b0, 2'h0, st, ps);
    chk({30'h0, st, ps}, 32'h0);
    rdc(8'hf8, 8'h08);
    apb(1'b1, 8'hfa, 8'h00);
    rdc(8'hfa, 8'h00);
    apb(1'b1, 8'hfb, 8'h01);
    feed.packet(3'h3, 5'h1d, 1'b0, 2'h0, st, ps);
    chk({31'h0, st}, 32'h1);
    rdc(8'hfb, 8'h09);
    apb(1'b1, 8'hfb, 8'h00);
    feed.packet(3'h3, 5'h1e, 1'b0, 2'h0, st, ps);
    chk({31'h0, st}, 32'h0);
    feed.packet(3'h3, 5'h05, 1'b1, 2'h0, st, ps);
    chk({31'h0, st}, 32'h0);
    rdc(8'hfb, 8'h20);
    apb(1'b1, 8'hfb, 8'h10);
    rdc(8'hfb, 8'h10);
    feed.packet(3'h3, 5'h05, 1'b1, 2'h0, st, ps);
    chk({31'h0, st}, 32'h1);
    $display("test storage done");
    stop_test();
  end
endmodule
